// File: hw/wit_top.sv
// Watchdog and interval timer top with register port and reset/interrupt outputs
// What this block does
// R1: Control writes must carry key 5Ah in the upper byte, word access only.
// R2: Control write with wrong key raises a power-up-clear reset in any mode.
// R3: Control word reads return 69h in the upper byte.
// R4: Counter is a hidden 16-bit up-counter steered by control fields.
// R5: Count clock is auxiliary or sub-main, chosen by the select bit.
// R6: After power-up clear, watchdog mode counts 32768 oscillator clock cycles.
// R7: Watchdog mode expiry raises a power-up-clear reset.
// R8: Power-up clear restores defaults and sets reset/NMI pin to reset function.
// R9: Mode bit set selects interval mode, clear selects watchdog mode.
// R10: Interval expiry sets the flag, no reset, enable unchanged.
// R11: Interval interrupt requested only when flag, enable and global enable set.
// R12: Interval flag clears on service or by software.
// R13: Interval interrupt vector differs from the watchdog reset vector.
// R14: Flag at bit 0 of flag register one, enable at bit 0 of enable register.
// R15: Watchdog reset by timeout or key violation sets the flag, kept for software.
// R16: Watchdog mode keeps requesting the selected count clock.
// R17: In watchdog mode a failed count clock falls back to main clock.
// R18: Interval mode has no clock request and no fail-safe switch.
// R19: Hold bit stops the counter and keeps its value.
// R20: Software should change interval with clear, and halt before clock change.
// R21: Count clock should not run faster than the main clock.
// R22: Interval codes 00..11 give 32768, 8192, 512, 64 count clocks.
// R23: Writing clear zeroes the counter; the bit always reads back zero.
// R24: Of the two resets only power-on reset clears the flag; it survives power-up clear.
// R25: Expiry is a one-cycle event on tap falling edge; counting continues.
`timescale 1ns/1ps
`default_nettype none
module wit_top (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        puc_n,
  input  wire logic [1:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [15:0] reg_rdata,
  input  wire logic        aux_clock,
  input  wire logic        sub_main_clock,
  input  wire logic        oscillator_clock,
  input  wire logic        main_clock,
  input  wire logic        aux_clock_fail,
  input  wire logic        sub_main_clock_fail,
  input  wire logic        global_irq_enable,
  input  wire logic        irq_serviced,
  output logic             power_up_clear_req,
  output logic             timer_irq_req,
  output logic             reset_vector_sel,
  output logic             nmi_pin_function,
  output logic             nmi_edge_falling,
  output logic             aux_clock_request,
  output logic             sub_main_clock_request
);
  // resetn is power-on reset; puc_n is the system power-up clear loop-back
  logic [7:0] ctrl_ff;
  logic       cfg_done_ff;
  logic       timer_irq_flag_ff;
  logic       timer_irq_enable_ff;
  logic       puc_pend_ff;
  logic [2:0] puc_cnt_ff;
  logic       key_bad;
  logic       ctrl_wr;
  logic       clear_now;
  logic       mode_irq;
  logic       sel_clk;
  logic       fail;
  logic       use_clk;
  logic       tick;
  logic       expire;
  logic       wd_event;
  logic       soft_rst_n;

  assign soft_rst_n = resetn & puc_n;
  assign ctrl_wr    = reg_write && (reg_addr == wit_pkg::ADDR_CTRL);
  assign key_bad    = ctrl_wr && (reg_wdata[15:8] != wit_pkg::WRITE_KEY); // R1
  assign clear_now  = ctrl_wr && !key_bad && reg_wdata[wit_pkg::BIT_CLEAR]; // R23
  assign mode_irq   = ctrl_ff[wit_pkg::BIT_MODE]; // R9

  // Control word; counter-clear bit is never stored
  always_ff @(posedge clk_sys) begin
    if (!soft_rst_n) begin
      ctrl_ff     <= wit_pkg::CTRL_RESET; // R8
      cfg_done_ff <= 1'b0;
    end else if (ctrl_wr && !key_bad) begin
      ctrl_ff     <= reg_wdata[7:0] & ~(8'h01 << wit_pkg::BIT_CLEAR);
      cfg_done_ff <= 1'b1;
    end
  end

  // Until first good write the oscillator clock drives the count (R6)
  assign sel_clk = ctrl_ff[wit_pkg::BIT_CLK_SEL] ? aux_clock : sub_main_clock; // R5
  assign fail    = ctrl_ff[wit_pkg::BIT_CLK_SEL] ? aux_clock_fail : sub_main_clock_fail;
  always_comb begin
    if (!cfg_done_ff) begin
      use_clk = oscillator_clock; // R6
    end else if (!mode_irq && fail) begin
      use_clk = main_clock; // R17
    end else begin
      use_clk = sel_clk; // R18
    end
  end

  wit_clk_edge u_edge (
    .clk_sys    (clk_sys),
    .resetn     (soft_rst_n),
    .level_in   (use_clk),
    .rise_pulse (tick)
  );

  wit_counter u_cnt (
    .clk_sys         (clk_sys),
    .resetn          (soft_rst_n),
    .tick            (tick),
    .hold            (ctrl_ff[wit_pkg::BIT_HOLD]),
    .clear           (clear_now),
    .interval_select (ctrl_ff[1:0]),
    .expire_pulse    (expire)
  );

  assign wd_event = key_bad || (expire && !mode_irq); // R2 R7

  // Flag survives power-up clear; set wins over software and service clears, power-on reset wins over set
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      timer_irq_flag_ff <= 1'b0; // R24
    end else if (wd_event || (expire && mode_irq)) begin
      timer_irq_flag_ff <= 1'b1; // R10 R15
    end else if (reg_write && reg_addr == wit_pkg::ADDR_FLAG && !reg_wdata[wit_pkg::BIT_TIRQ]) begin
      timer_irq_flag_ff <= 1'b0; // R12
    end else if (irq_serviced && mode_irq) begin
      timer_irq_flag_ff <= 1'b0; // R12
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!soft_rst_n) begin
      timer_irq_enable_ff <= 1'b0;
    end else if (reg_write && reg_addr == wit_pkg::ADDR_ENABLE) begin
      timer_irq_enable_ff <= reg_wdata[wit_pkg::BIT_TIRQ]; // R14
    end
  end

  // Stretched reset request so the system sees it for several cycles
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      puc_pend_ff <= 1'b0;
      puc_cnt_ff  <= 3'h0;
    end else if (wd_event) begin
      puc_pend_ff <= 1'b1;
      puc_cnt_ff  <= 3'(wit_pkg::RESET_PULSE_CYC - 1);
    end else if (puc_cnt_ff != 3'h0) begin
      puc_cnt_ff  <= puc_cnt_ff - 3'h1;
    end else begin
      puc_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      power_up_clear_req     <= 1'b0;
      timer_irq_req          <= 1'b0;
      reset_vector_sel       <= 1'b0;
      nmi_pin_function       <= 1'b0;
      nmi_edge_falling       <= 1'b0;
      aux_clock_request      <= 1'b0;
      sub_main_clock_request <= 1'b0;
    end else begin
      power_up_clear_req     <= puc_pend_ff || wd_event;
      timer_irq_req          <= mode_irq && timer_irq_flag_ff && timer_irq_enable_ff && global_irq_enable; // R11
      reset_vector_sel       <= !mode_irq && timer_irq_flag_ff; // R13
      nmi_pin_function       <= ctrl_ff[wit_pkg::BIT_NMI_SEL]; // R8
      nmi_edge_falling       <= ctrl_ff[wit_pkg::BIT_NMI_EDGE];
      aux_clock_request      <= !mode_irq && ctrl_ff[wit_pkg::BIT_CLK_SEL]; // R16
      sub_main_clock_request <= !mode_irq && !ctrl_ff[wit_pkg::BIT_CLK_SEL]; // R16
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      if (reg_addr == wit_pkg::ADDR_CTRL) begin
        reg_rdata <= {wit_pkg::READ_KEY, ctrl_ff}; // R3
      end else if (reg_addr == wit_pkg::ADDR_ENABLE) begin
        reg_rdata <= {15'h0000, timer_irq_enable_ff};
      end else if (reg_addr == wit_pkg::ADDR_FLAG) begin
        reg_rdata <= {15'h0000, timer_irq_flag_ff};
      end else begin
        reg_rdata <= {13'h0000, fail, mode_irq, puc_pend_ff};
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  a_key_reset: assert property (@(posedge clk_sys) disable iff (!resetn)
    key_bad |=> power_up_clear_req [*4]) else $error("bad key gave no reset"); // R2
  a_read_key: assert property (@(posedge clk_sys) disable iff (!resetn)
    reg_read && reg_addr == wit_pkg::ADDR_CTRL |=> reg_rdata[15:8] == 8'h69) else $error("read key wrong"); // R3
  a_wd_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
    wd_event |=> timer_irq_flag_ff) else $error("flag not set on watchdog reset"); // R15
  a_irq_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
    timer_irq_req |-> $past(timer_irq_enable_ff) && $past(global_irq_enable)) else $error("irq without enables"); // R11
  a_no_puc_int: assert property (@(posedge clk_sys) disable iff (!resetn)
    expire && mode_irq && !key_bad |=> !power_up_clear_req || $past(puc_pend_ff)) else $error("reset in interval mode"); // R10
  a_clk_req: assert property (@(posedge clk_sys) disable iff (!resetn)
    mode_irq |=> !aux_clock_request && !sub_main_clock_request) else $error("clock kept in interval mode"); // R18
  a_clear_read: assert property (@(posedge clk_sys) disable iff (!resetn)
    reg_read && reg_addr == wit_pkg::ADDR_CTRL |=> !reg_rdata[3]) else $error("clear bit read as one"); // R23
  a_wd_expiry: assert property (@(posedge clk_sys) disable iff (!resetn)
    expire && !mode_irq |=> power_up_clear_req) else $error("watchdog expiry gave no reset"); // R7
  a_flag_kept: assert property (@(posedge clk_sys) disable iff (!resetn)
    !puc_n && timer_irq_flag_ff && !reg_write && !irq_serviced |=> timer_irq_flag_ff)
    else $error("flag lost in power-up clear"); // R24
  a_vec_sel: assert property (@(posedge clk_sys) disable iff (!resetn)
    !mode_irq && timer_irq_flag_ff |=> reset_vector_sel) else $error("reset vector not selected"); // R13
  a_clk_keep: assert property (@(posedge clk_sys) disable iff (!resetn)
    !mode_irq |=> aux_clock_request || sub_main_clock_request) else $error("count clock not kept"); // R16
endmodule : wit_top
`default_nettype wire

// File: hw/wit_pkg.sv
// Constants shared by the watchdog interval timer
package wit_pkg;
  localparam logic [7:0]  WRITE_KEY        = 8'h5a;
  localparam logic [7:0]  READ_KEY         = 8'h69;
  localparam logic [1:0]  ADDR_CTRL        = 2'h0;
  localparam logic [1:0]  ADDR_ENABLE      = 2'h1;
  localparam logic [1:0]  ADDR_FLAG        = 2'h2;
  localparam logic [1:0]  ADDR_STATUS      = 2'h3;
  localparam int          BIT_HOLD         = 7;
  localparam int          BIT_NMI_EDGE     = 6;
  localparam int          BIT_NMI_SEL      = 5;
  localparam int          BIT_MODE         = 4;
  localparam int          BIT_CLEAR        = 3;
  localparam int          BIT_CLK_SEL      = 2;
  localparam int          BIT_TIRQ         = 0;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
  localparam logic [15:0] CNT_ZERO         = 16'h0000;
  localparam int          TAP_32768        = 14;
  localparam int          TAP_8192         = 12;
  localparam int          TAP_512          = 8;
  localparam int          TAP_64           = 5;
  localparam int          RESET_PULSE_CYC  = 4;
endpackage : wit_pkg

// File: hw/wit_clk_edge.sv
// Rising-edge detector for a count clock sampled as a level
`timescale 1ns/1ps
`default_nettype none
module wit_clk_edge (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic level_in,
  output logic      rise_pulse
);
  logic prev_ff;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= level_in;
    end
  end
  assign rise_pulse = level_in & ~prev_ff;
endmodule : wit_clk_edge
`default_nettype wire

// File: hw/wit_counter.sv
// Sixteen-bit up-counter with clear, hold and tap falling-edge detect
`timescale 1ns/1ps
`default_nettype none
module wit_counter (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       tick,
  input  wire logic       hold,
  input  wire logic       clear,
  input  wire logic [1:0] interval_select,
  output logic            expire_pulse
);
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic        tap_now;
  logic        tap_nxt;
  always_comb begin
    nxt_cnt = cnt_ff;
    if (clear) begin
      nxt_cnt = wit_pkg::CNT_ZERO; // R23
    end else if (tick && !hold) begin // R19
      nxt_cnt = cnt_ff + 16'h0001; // R4
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt_ff <= wit_pkg::CNT_ZERO;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
  // R22
  always_comb begin
    case (interval_select)
      2'h0:    begin tap_now = cnt_ff[wit_pkg::TAP_32768]; tap_nxt = nxt_cnt[wit_pkg::TAP_32768]; end
      2'h1:    begin tap_now = cnt_ff[wit_pkg::TAP_8192];  tap_nxt = nxt_cnt[wit_pkg::TAP_8192]; end
      2'h2:    begin tap_now = cnt_ff[wit_pkg::TAP_512];   tap_nxt = nxt_cnt[wit_pkg::TAP_512]; end
      default: begin tap_now = cnt_ff[wit_pkg::TAP_64];    tap_nxt = nxt_cnt[wit_pkg::TAP_64]; end
    endcase
  end
  // Falling edge of the tap bit marks a full interval from zero
  assign expire_pulse = tick && !hold && !clear && tap_now && !tap_nxt; // R25

  a_hold_keeps: assert property (@(posedge clk_sys) disable iff (!resetn)
    hold && !clear |=> cnt_ff == $past(cnt_ff)) else $error("counter moved while held"); // R19
  a_clear_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
    clear |=> cnt_ff == wit_pkg::CNT_ZERO) else $error("counter not zeroed by clear"); // R23
endmodule : wit_counter
`default_nettype wire

// File: bench/wit_sys_model.sv
// System reset and interrupt service stand-in for the timer
`timescale 1ns/1ps
`default_nettype none
module wit_sys_model (
  input  wire logic clk_sys,
  input  wire logic power_up_clear_req,
  input  wire logic timer_irq_req,
  output logic      puc_n,
  output logic      irq_serviced
);
  logic [1:0] svc_cnt_ff = 2'h0;
  initial puc_n = 1'b1;
  initial irq_serviced = 1'b0;
  // Clear held for as long as the request stands
  always @(posedge clk_sys) begin
    puc_n <= ~power_up_clear_req;
  end
  // Acknowledge late, as a busy CPU would
  always @(posedge clk_sys) begin
    svc_cnt_ff   <= timer_irq_req ? svc_cnt_ff + 2'h1 : 2'h0;
    irq_serviced <= timer_irq_req && svc_cnt_ff == 2'h2;
  end
endmodule : wit_sys_model
`default_nettype wire

// File: bench/tb_top.sv
// Register-port testbench for the watchdog interval timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [1:0]  reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic        aux_clock = 1'b0, sub_main_clock = 1'b0, oscillator_clock = 1'b0, main_clock = 1'b0;
  logic        aux_clock_fail = 1'b0, global_irq_enable = 1'b0, aux_stop = 1'b0;
  logic        puc_n, irq_serviced, power_up_clear_req, timer_irq_req, reset_vector_sel;
  logic        nmi_pin_function, nmi_edge_falling, aux_clock_request, sub_main_clock_request;
  int          fails = 0, comparisons = 0;

  always #2.5 clk_sys = ~clk_sys;
  // Count clocks at half the system rate; aux can be stopped to fake a failure
  always @(posedge clk_sys) begin
    aux_clock        <= ~aux_clock & ~aux_stop;
    main_clock       <= ~main_clock;
    oscillator_clock <= ~oscillator_clock;
    sub_main_clock   <= ~sub_main_clock;
  end

  wit_top dut (.clk_sys(clk_sys), .resetn(resetn), .puc_n(puc_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .aux_clock(aux_clock), .sub_main_clock(sub_main_clock), .oscillator_clock(oscillator_clock),
    .main_clock(main_clock), .aux_clock_fail(aux_clock_fail), .sub_main_clock_fail(1'b0),
    .global_irq_enable(global_irq_enable), .irq_serviced(irq_serviced),
    .power_up_clear_req(power_up_clear_req), .timer_irq_req(timer_irq_req),
    .reset_vector_sel(reset_vector_sel), .nmi_pin_function(nmi_pin_function),
    .nmi_edge_falling(nmi_edge_falling),
    .aux_clock_request(aux_clock_request), .sub_main_clock_request(sub_main_clock_request));

  wit_sys_model sys (.clk_sys(clk_sys), .power_up_clear_req(power_up_clear_req),
    .timer_irq_req(timer_irq_req), .puc_n(puc_n), .irq_serviced(irq_serviced));

  task automatic summarize;
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rdc(input string name, input logic [1:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 chk(name, exp, reg_rdata);
  endtask : rdc

  task automatic wait_for(input int which, input int lim);
    int n;
    n = 0;
    while (n < lim && (which == 0 ? power_up_clear_req : timer_irq_req) !== 1'b1) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk("wait", 16'h0001, {15'h0000, n < lim});
  endtask : wait_for

  initial begin
    #20000;
    fails++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    rdc("ctrl", 2'h0, 16'h6900);
    rdc("flag", 2'h2, 16'h0000);
    wr(2'h0, 16'h5a88);
    rdc("ctrl", 2'h0, 16'h6980);
    chk("smreq", 16'h0001, {15'h0000, sub_main_clock_request});
    wr(2'h1, 16'h0001);
    wr(2'h0, 16'h5a1f);
    repeat (300) @(posedge clk_sys);
    #1 chk("irq", 16'h0000, {15'h0000, timer_irq_req});
    chk("auxreq", 16'h0000, {15'h0000, aux_clock_request});
    chk("puc", 16'h0000, {15'h0000, power_up_clear_req});
    chk("vec", 16'h0000, {15'h0000, reset_vector_sel});
    rdc("flag", 2'h2, 16'h0001);
    rdc("enable", 2'h1, 16'h0001);
    wr(2'h0, 16'h5a9f);
    wr(2'h2, 16'h0000);
    repeat (300) @(posedge clk_sys);
    rdc("flag", 2'h2, 16'h0000);
    global_irq_enable <= 1'b1;
    wr(2'h0, 16'h5a1f);
    wait_for(1, 300);
    repeat (10) @(posedge clk_sys);
    rdc("flag", 2'h2, 16'h0000);
    global_irq_enable <= 1'b0;
    aux_stop <= 1'b1;
    aux_clock_fail <= 1'b1;
    wr(2'h0, 16'h5a6f);
    @(posedge clk_sys);
    #1 chk("nmi", 16'h0001, {15'h0000, nmi_pin_function});
    chk("nmiedge", 16'h0001, {15'h0000, nmi_edge_falling});
    chk("auxreq", 16'h0001, {15'h0000, aux_clock_request});
    rdc("status", 2'h3, 16'h0004);
    wait_for(0, 400);
    repeat (12) @(posedge clk_sys);
    rdc("ctrl", 2'h0, 16'h6900);
    rdc("flag", 2'h2, 16'h0001);
    chk("nmi", 16'h0000, {15'h0000, nmi_pin_function});
    chk("nmiedge", 16'h0000, {15'h0000, nmi_edge_falling});
    chk("vec", 16'h0001, {15'h0000, reset_vector_sel});
    wr(2'h2, 16'h0000);
    wr(2'h0, 16'h1200);
    #1 chk("puc", 16'h0001, {15'h0000, power_up_clear_req});
    repeat (12) @(posedge clk_sys);
    rdc("flag", 2'h2, 16'h0001);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
